// [dwte_top.sv]
// Trigger, pause and buffered sequencing engine for digital waveform input and output
`timescale 1ns/100ps
`include "dwte_map.svh"

// What this block does
// - Acquisition starts on armed start trigger, or on software go without trigger.
// - Finite ends at sample count or reference trigger; continuous ends by stop or, if enabled, by reference trigger.
// - Retriggerable start replays the whole finite sample sequence per trigger.
// - Start triggers during a sequence are ignored; re-arm after it ends.
// - Only one reference trigger is honoured per acquisition.
// - Start trigger edge is selectable rising or falling.
// - Exported start trigger is an active-high pulse; line is input after reset.
// - Posttrigger samples equal buffer size minus pretrigger count.
// - Reference trigger is armed only after pretrigger samples are stored.
// - Full buffer before reference trigger drops the oldest sample per new one.
// - After reference trigger, store posttrigger samples then end.
// - Reference trigger edge is selectable rising or falling.
// - Software go also starts pretriggered acquisitions.
// - Active pause suppresses the sample clock; clocking resumes when inactive.
// - Pause active level is programmable high or low.
// - Pause is level sensitive only.
// - Single point mode flags lateness when previous sample is still unread.
// - Host fills generation FIFO; one sample goes out per update.
// - Finite generation stops after exactly the programmed sample count.
// - Regeneration replays stored data and is allowed after reset.
// - Without regeneration, data is never repeated; empty update flags underflow.
// - FIFO-only replay refuses host writes while running.
// - External sample clock edges are ignored outside an acquisition.
// - Without reference trigger, a sample arriving into a full acquisition FIFO flags overflow.
// - Start to first sample delay is programmable, two ticks after reset.
module dwte_top (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Trigger and clock inputs
    input  wire logic        INPUT_START_TRIGGER,
    input  wire logic        INPUT_REFERENCE_TRIGGER,
    input  wire logic        INPUT_PAUSE_TRIGGER,
    input  wire logic        INPUT_SAMPLE_CLOCK,
    // Waveform data
    input  wire logic [7:0]  DI_DATA_I,
    output logic      [7:0]  DO_DATA_O,
    // Start trigger export line
    input  wire logic        PROGRAMMABLE_IO_LINE_I,
    output logic             PROGRAMMABLE_IO_LINE_O,
    output logic             PROGRAMMABLE_IO_LINE_OE,
    // Status
    output logic             ACQ_ACTIVE_O
);

    dwte_pkg::dwte_st_t  q_r;
    dwte_pkg::dwte_st_t  q_nxt;
    dwte_pkg::dwte_wbi_t wbi;
    logic                req;
    logic                commit;
    logic                wr;
    logic [7:0]          wa;
    logic [3:0]          rise;
    logic [3:0]          fall;
    logic                start_ev;
    logic                ref_ev;
    logic                paused;
    logic                tick;
    logic                gtick;
    logic                acq_end;
    logic                regen;
    logic [15:0]         post_tgt;
    logic [3:0]          nx;
    logic [31:0]         rd_val;
    logic                acq_go;
    logic                acq_stop;
    logic                gen_go;
    logic                gen_stop;
    logic                err_clr;

    function automatic logic edge_hit(input logic r, input logic f, input logic sel_fall);
        edge_hit = sel_fall ? f : r;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    assign wbi = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                   sel: WB_SEL_I, dat: WB_DAT_I};

    always_comb
    begin
        q_nxt = q_r;
        rd_val = 32'h0000_0000;
        tick = 1'b0;
        gtick = 1'b0;
        acq_end = 1'b0;
        nx = 4'h0;
        q_nxt.wb_ack = 1'b0;
        q_nxt.exp_pulse = 1'b0;

        // Input synchronisers and agreement filter
        q_nxt.s1 = {INPUT_SAMPLE_CLOCK, INPUT_PAUSE_TRIGGER,
                    INPUT_REFERENCE_TRIGGER, INPUT_START_TRIGGER};
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        for (int i = 0; i < 4; i++)
        begin
            if (q_r.s2[i] == q_r.s3[i])
            begin
                q_nxt.flt[i] = q_r.s3[i];
            end
        end
        q_nxt.prv = q_r.flt;
        q_nxt.d1 = DI_DATA_I;
        q_nxt.d2 = q_r.d1;
        q_nxt.d3 = q_r.d2;
        rise = q_r.flt & ~q_r.prv;
        fall = ~q_r.flt & q_r.prv;
        start_ev = edge_hit(rise[`DWTE_TRG_START], fall[`DWTE_TRG_START],
                            q_r.acq_cfg[`DWTE_ACQ_START_FALL]);
        ref_ev = edge_hit(rise[`DWTE_TRG_REF], fall[`DWTE_TRG_REF],
                          q_r.acq_cfg[`DWTE_ACQ_REF_FALL]);
        paused = q_r.acq_cfg[`DWTE_ACQ_PAUSE_EN] &
                 (q_r.flt[`DWTE_TRG_PAUSE] ^ q_r.acq_cfg[`DWTE_ACQ_PAUSE_LOW]);
        post_tgt = q_r.acq_cnt - q_r.pre_cnt;
        regen = q_r.gen_cfg[`DWTE_GEN_REGENERATION_ALLOW] |
                q_r.gen_cfg[`DWTE_GEN_FIFO_ONLY_REPLAY];

        // Bus decode
        req = wbi.cyc & wbi.stb;
        commit = req & q_r.wb_ack;
        wr = commit & wbi.we;
        wa = {wbi.adr[7:2], 2'b00};
        if (wa == `DWTE_OFF_ACQ_CFG)
        begin
            rd_val = {21'h000000, q_r.acq_cfg};
        end
        else if (wa == `DWTE_OFF_ACQ_CNT)
        begin
            rd_val = {16'h0000, q_r.acq_cnt};
        end
        else if (wa == `DWTE_OFF_PRE_CNT)
        begin
            rd_val = {16'h0000, q_r.pre_cnt};
        end
        else if (wa == `DWTE_OFF_DELAY)
        begin
            rd_val = {16'h0000, q_r.delay};
        end
        else if (wa == `DWTE_OFF_PERIOD)
        begin
            rd_val = {16'h0000, q_r.period};
        end
        else if (wa == `DWTE_OFF_STATUS)
        begin
            rd_val = {11'h000, q_r.gcount, 3'h0, q_r.acount, 1'b0, q_r.late, q_r.unf,
                      q_r.ovf, q_r.trig_seen, q_r.pre_ok,
                      q_r.gen_st == dwte_pkg::GEN_RUN, q_r.acq_st != dwte_pkg::ACQ_IDLE};
        end
        else if (wa == `DWTE_OFF_ACQ_DATA)
        begin
            rd_val = {24'h000000, q_r.amem[q_r.arp]};
        end
        else if (wa == `DWTE_OFF_GEN_CFG)
        begin
            rd_val = {29'h00000000, q_r.gen_cfg};
        end
        else if (wa == `DWTE_OFF_GEN_CNT)
        begin
            rd_val = {16'h0000, q_r.gen_cnt};
        end
        if (req && !q_r.wb_ack)
        begin
            q_nxt.wb_ack = 1'b1;
            q_nxt.wb_dat = rd_val;
        end
        acq_go = wr && wa == `DWTE_OFF_CTRL && wbi.sel[0] && wbi.dat[`DWTE_CTRL_ACQ_GO];
        acq_stop = wr && wa == `DWTE_OFF_CTRL && wbi.sel[0] && wbi.dat[`DWTE_CTRL_ACQ_STOP];
        gen_go = wr && wa == `DWTE_OFF_CTRL && wbi.sel[0] && wbi.dat[`DWTE_CTRL_GEN_GO];
        gen_stop = wr && wa == `DWTE_OFF_CTRL && wbi.sel[0] && wbi.dat[`DWTE_CTRL_GEN_STOP];
        err_clr = wr && wa == `DWTE_OFF_CTRL && wbi.sel[0] && wbi.dat[`DWTE_CTRL_ERR_CLR];
        if (wr && wa == `DWTE_OFF_ACQ_CFG)
        begin
            q_nxt.acq_cfg = {wbi.sel[1] ? wbi.dat[10:8] : q_r.acq_cfg[10:8],
                             wbi.sel[0] ? wbi.dat[7:0] : q_r.acq_cfg[7:0]};
        end
        else if (wr && wa == `DWTE_OFF_ACQ_CNT)
        begin
            q_nxt.acq_cnt = merge16(q_r.acq_cnt, wbi.dat, wbi.sel);
        end
        else if (wr && wa == `DWTE_OFF_PRE_CNT)
        begin
            q_nxt.pre_cnt = merge16(q_r.pre_cnt, wbi.dat, wbi.sel);
        end
        else if (wr && wa == `DWTE_OFF_DELAY)
        begin
            q_nxt.delay = merge16(q_r.delay, wbi.dat, wbi.sel);
        end
        else if (wr && wa == `DWTE_OFF_PERIOD)
        begin
            q_nxt.period = merge16(q_r.period, wbi.dat, wbi.sel);
        end
        else if (wr && wa == `DWTE_OFF_GEN_CFG && wbi.sel[0])
        begin
            q_nxt.gen_cfg = wbi.dat[2:0];
        end
        else if (wr && wa == `DWTE_OFF_GEN_CNT)
        begin
            q_nxt.gen_cnt = merge16(q_r.gen_cnt, wbi.dat, wbi.sel);
        end
        if (err_clr)
        begin
            q_nxt.ovf = 1'b0;
            q_nxt.unf = 1'b0;
            q_nxt.late = 1'b0;
        end

        // Host drains the acquisition FIFO
        if (commit && !wbi.we && wa == `DWTE_OFF_ACQ_DATA && q_r.acount != 5'h00)
        begin
            q_nxt.arp = q_r.arp + 4'h1;
            q_nxt.acount = q_r.acount - 5'h01;
        end

        // Acquisition sequencer
        case (q_r.acq_st)
            dwte_pkg::ACQ_IDLE:
            begin
                if (acq_go)
                begin
                    q_nxt.smp = 16'h0000;
                    q_nxt.post = 16'h0000;
                    q_nxt.pre_ok = 1'b0;
                    q_nxt.trig_seen = 1'b0;
                    q_nxt.dly = q_r.delay;
                    q_nxt.acq_st = q_r.acq_cfg[`DWTE_ACQ_TRIG_EN] ?
                                   dwte_pkg::ACQ_ARM : dwte_pkg::ACQ_DELAY;
                end
            end
            dwte_pkg::ACQ_ARM:
            begin
                if (start_ev)
                begin
                    q_nxt.acq_st = dwte_pkg::ACQ_DELAY;
                    q_nxt.trig_seen = 1'b0;
                    q_nxt.dly = q_r.delay;
                    q_nxt.exp_pulse = q_r.acq_cfg[`DWTE_ACQ_EXPORT_EN];
                end
            end
            dwte_pkg::ACQ_DELAY:
            begin
                if (q_r.dly <= 16'h0001)
                begin
                    q_nxt.acq_st = dwte_pkg::ACQ_RUN;
                    q_nxt.div = 16'h0000;
                end
                else
                begin
                    q_nxt.dly = q_r.dly - 16'h0001;
                end
            end
            dwte_pkg::ACQ_RUN:
            begin
                if (q_r.acq_cfg[`DWTE_ACQ_EXT_CLK])
                begin
                    tick = rise[`DWTE_TRG_SCLK] & ~paused;
                end
                else if (!paused)
                begin
                    if (q_r.div == 16'h0000)
                    begin
                        tick = 1'b1;
                        q_nxt.div = q_r.period - 16'h0001;
                    end
                    else
                    begin
                        q_nxt.div = q_r.div - 16'h0001;
                    end
                end
                if (q_r.smp >= q_r.pre_cnt)
                begin
                    q_nxt.pre_ok = 1'b1;
                end
                if (q_r.acq_cfg[`DWTE_ACQ_REF_EN] && q_r.pre_ok &&
                    !q_r.trig_seen && ref_ev)
                begin
                    q_nxt.trig_seen = 1'b1;
                    if (post_tgt == 16'h0000)
                    begin
                        acq_end = 1'b1;
                    end
                end
                if (tick)
                begin
                    if (q_r.acq_cfg[`DWTE_ACQ_TIMED_SINGLE_POINT] &&
                        q_nxt.acount != 5'h00)
                    begin
                        q_nxt.late = 1'b1;
                    end
                    if (q_r.acq_cfg[`DWTE_ACQ_REF_EN] &&
                        ({11'h000, q_nxt.acount} >= q_r.acq_cnt ||
                         q_nxt.acount == `DWTE_DEPTH))
                    begin
                        q_nxt.arp = q_nxt.arp + 4'h1;
                        q_nxt.acount = q_nxt.acount - 5'h01;
                    end
                    if (q_nxt.acount == `DWTE_DEPTH)
                    begin
                        q_nxt.ovf = 1'b1;
                    end
                    else
                    begin
                        q_nxt.amem[q_r.awp] = q_r.d3;
                        q_nxt.awp = q_r.awp + 4'h1;
                        q_nxt.acount = q_nxt.acount + 5'h01;
                    end
                    q_nxt.smp = q_r.smp + 16'h0001;
                    if (q_r.acq_cfg[`DWTE_ACQ_REF_EN])
                    begin
                        if (q_r.trig_seen)
                        begin
                            q_nxt.post = q_r.post + 16'h0001;
                            if (q_r.post + 16'h0001 >= post_tgt)
                            begin
                                acq_end = 1'b1;
                            end
                        end
                    end
                    else if (!q_r.acq_cfg[`DWTE_ACQ_CONT] &&
                             q_r.smp + 16'h0001 == q_r.acq_cnt)
                    begin
                        acq_end = 1'b1;
                    end
                end
                if (acq_end)
                begin
                    q_nxt.smp = 16'h0000;
                    q_nxt.post = 16'h0000;
                    q_nxt.pre_ok = 1'b0;
                    q_nxt.acq_st = (q_r.acq_cfg[`DWTE_ACQ_RETRIG] &&
                                    q_r.acq_cfg[`DWTE_ACQ_TRIG_EN]) ?
                                   dwte_pkg::ACQ_ARM : dwte_pkg::ACQ_IDLE;
                end
            end
            default:
            begin
                q_nxt.acq_st = dwte_pkg::ACQ_IDLE;
            end
        endcase
        if (acq_stop)
        begin
            q_nxt.acq_st = dwte_pkg::ACQ_IDLE;
        end

        // Generation sequencer
        case (q_r.gen_st)
            dwte_pkg::GEN_IDLE:
            begin
                if (gen_go)
                begin
                    q_nxt.gen_st = dwte_pkg::GEN_RUN;
                    q_nxt.gdiv = q_r.delay;
                    q_nxt.gsent = 16'h0000;
                end
            end
            default:
            begin
                if (q_r.gdiv == 16'h0000)
                begin
                    gtick = 1'b1;
                    q_nxt.gdiv = q_r.period - 16'h0001;
                end
                else
                begin
                    q_nxt.gdiv = q_r.gdiv - 16'h0001;
                end
                if (gtick)
                begin
                    if (q_r.gcount == 5'h00)
                    begin
                        q_nxt.unf = 1'b1;
                    end
                    else
                    begin
                        q_nxt.gout = q_r.gmem[q_r.grp];
                        if (regen)
                        begin
                            nx = q_r.grp + 4'h1;
                            if (nx == q_r.gwp)
                            begin
                                nx = q_r.gwp - q_r.gcount[3:0];
                            end
                            q_nxt.grp = nx;
                        end
                        else
                        begin
                            q_nxt.grp = q_r.grp + 4'h1;
                            q_nxt.gcount = q_r.gcount - 5'h01;
                        end
                    end
                    q_nxt.gsent = q_r.gsent + 16'h0001;
                    if (!q_r.gen_cfg[`DWTE_GEN_CONT] &&
                        q_r.gsent + 16'h0001 == q_r.gen_cnt)
                    begin
                        q_nxt.gen_st = dwte_pkg::GEN_IDLE;
                    end
                end
            end
        endcase
        if (gen_stop)
        begin
            q_nxt.gen_st = dwte_pkg::GEN_IDLE;
        end

        // Host fills the generation FIFO
        if (wr && wa == `DWTE_OFF_GEN_DATA && wbi.sel[0] && q_nxt.gcount != `DWTE_DEPTH &&
            !(q_r.gen_cfg[`DWTE_GEN_FIFO_ONLY_REPLAY] &&
              q_r.gen_st == dwte_pkg::GEN_RUN))
        begin
            q_nxt.gmem[q_r.gwp] = wbi.dat[7:0];
            q_nxt.gwp = q_r.gwp + 4'h1;
            q_nxt.gcount = q_nxt.gcount + 5'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            q_r <= '0;
            q_r.acq_cnt <= `DWTE_RST_ACQ_CNT;
            q_r.pre_cnt <= `DWTE_RST_PRE_CNT;
            q_r.delay <= `DWTE_RST_DELAY;
            q_r.period <= `DWTE_RST_PERIOD;
            q_r.gen_cfg <= `DWTE_RST_GEN_CFG;
            q_r.gen_cnt <= `DWTE_RST_GEN_CNT;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign WB_DAT_O = q_r.wb_dat;
    assign WB_ACK_O = q_r.wb_ack;
    assign DO_DATA_O = q_r.gout;
    assign PROGRAMMABLE_IO_LINE_O = q_r.exp_pulse;
    assign PROGRAMMABLE_IO_LINE_OE = q_r.acq_cfg[`DWTE_ACQ_EXPORT_EN];
    assign ACQ_ACTIVE_O = q_r.acq_st != dwte_pkg::ACQ_IDLE;

endmodule // dwte_top

// [dwte_map.svh]
// Register offsets, field positions, reset values and sizes of the trigger engine
`ifndef DWTE_MAP_SVH
`define DWTE_MAP_SVH
`define DWTE_OFF_CTRL        8'h00
`define DWTE_OFF_ACQ_CFG     8'h04
`define DWTE_OFF_ACQ_CNT     8'h08
`define DWTE_OFF_PRE_CNT     8'h0C
`define DWTE_OFF_DELAY       8'h10
`define DWTE_OFF_PERIOD      8'h14
`define DWTE_OFF_STATUS      8'h18
`define DWTE_OFF_ACQ_DATA    8'h1C
`define DWTE_OFF_GEN_CFG     8'h20
`define DWTE_OFF_GEN_CNT     8'h24
`define DWTE_OFF_GEN_DATA    8'h28
`define DWTE_CTRL_ACQ_GO     0
`define DWTE_CTRL_ACQ_STOP   1
`define DWTE_CTRL_GEN_GO     2
`define DWTE_CTRL_GEN_STOP   3
`define DWTE_CTRL_ERR_CLR    4
`define DWTE_ACQ_TRIG_EN     0
`define DWTE_ACQ_START_FALL  1
`define DWTE_ACQ_RETRIG      2
`define DWTE_ACQ_CONT        3
`define DWTE_ACQ_REF_EN      4
`define DWTE_ACQ_REF_FALL    5
`define DWTE_ACQ_PAUSE_EN    6
`define DWTE_ACQ_PAUSE_LOW   7
`define DWTE_ACQ_EXPORT_EN   8
`define DWTE_ACQ_TIMED_SINGLE_POINT 9
`define DWTE_ACQ_EXT_CLK     10
`define DWTE_GEN_CONT        0
`define DWTE_GEN_REGENERATION_ALLOW 1
`define DWTE_GEN_FIFO_ONLY_REPLAY   2
`define DWTE_RST_GEN_CFG     3'h2
`define DWTE_RST_ACQ_CNT     16'h0010
`define DWTE_RST_PRE_CNT     16'h0000
`define DWTE_RST_DELAY       16'h0002
`define DWTE_RST_PERIOD      16'h000A
`define DWTE_RST_GEN_CNT     16'h0010
`define DWTE_DEPTH           5'h10
`define DWTE_TRG_START       0
`define DWTE_TRG_REF         1
`define DWTE_TRG_PAUSE       2
`define DWTE_TRG_SCLK        3
`endif

// [dwte_pkg.sv]
// Types of the trigger engine: states, bus carrier and the state record
package dwte_pkg;
    typedef enum logic [1:0] {ACQ_IDLE, ACQ_ARM, ACQ_DELAY, ACQ_RUN} dwte_acq_t;
    typedef enum logic {GEN_IDLE, GEN_RUN} dwte_gen_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dwte_wbi_t;
    typedef struct packed {
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       s3;
        logic [3:0]       flt;
        logic [3:0]       prv;
        logic [7:0]       d1;
        logic [7:0]       d2;
        logic [7:0]       d3;
        logic [10:0]      acq_cfg;
        logic [15:0]      acq_cnt;
        logic [15:0]      pre_cnt;
        logic [15:0]      delay;
        logic [15:0]      period;
        logic [2:0]       gen_cfg;
        logic [15:0]      gen_cnt;
        dwte_acq_t        acq_st;
        logic [15:0]      div;
        logic [15:0]      dly;
        logic [15:0]      smp;
        logic [15:0]      post;
        logic             pre_ok;
        logic             trig_seen;
        logic [15:0][7:0] amem;
        logic [3:0]       awp;
        logic [3:0]       arp;
        logic [4:0]       acount;
        logic             ovf;
        logic             unf;
        logic             late;
        logic             exp_pulse;
        dwte_gen_t        gen_st;
        logic [15:0]      gdiv;
        logic [15:0]      gsent;
        logic [7:0]       gout;
        logic [15:0][7:0] gmem;
        logic [3:0]       gwp;
        logic [3:0]       grp;
        logic [4:0]       gcount;
        logic             wb_ack;
        logic [31:0]      wb_dat;
    } dwte_st_t;
endpackage

// [dwte_sva.sv]
// Port assertions and covers of the trigger engine
`timescale 1ns/100ps
`include "dwte_map.svh"
module dwte_sva (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    // Bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Export line and status
    input wire logic        PROGRAMMABLE_IO_LINE_O,
    input wire logic        PROGRAMMABLE_IO_LINE_OE,
    input wire logic        ACQ_ACTIVE_O
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_ack_answers: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not acknowledged");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_ctrl_reads_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == `DWTE_OFF_CTRL
        |-> WB_DAT_O == 32'h0) else $error("command register read not zero");
    a_export_pulse: assert property (PROGRAMMABLE_IO_LINE_O |=> !PROGRAMMABLE_IO_LINE_O)
        else $error("export pulse too long");
    a_export_driven: assert property (PROGRAMMABLE_IO_LINE_O |-> PROGRAMMABLE_IO_LINE_OE)
        else $error("export pulse on undriven line");
    a_export_in_acq: assert property (PROGRAMMABLE_IO_LINE_O |-> ACQ_ACTIVE_O)
        else $error("export pulse outside acquisition");
    a_powerup_input: assert property ($rose(RST_N) |-> !PROGRAMMABLE_IO_LINE_OE && !ACQ_ACTIVE_O)
        else $error("line not input after reset");
    c_export: cover property (PROGRAMMABLE_IO_LINE_O);
    c_acq_end: cover property ($fell(ACQ_ACTIVE_O));
    c_write: cover property (WB_ACK_O && WB_WE_I);
endmodule // dwte_sva
bind dwte_top dwte_sva i_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .PROGRAMMABLE_IO_LINE_O(PROGRAMMABLE_IO_LINE_O),
    .PROGRAMMABLE_IO_LINE_OE(PROGRAMMABLE_IO_LINE_OE), .ACQ_ACTIVE_O(ACQ_ACTIVE_O));

// [dwte_trig_src.sv]
// External trigger sources: lines idle at a set level and give timed pulses
`timescale 1ns/100ps
module dwte_trig_src #(parameter int WIDTH = 12) (
    // Clock and control
    input  wire logic       clk,
    input  wire logic [3:0] idle_lvl,
    input  wire logic [3:0] fire,
    // Lines towards the engine
    output logic      [3:0] trig
);
    logic [3:0][7:0] cnt_r = '0;
    always @(posedge clk)
        for (int i = 0; i < 4; i++)
            cnt_r[i] <= fire[i] ? 8'(WIDTH) : cnt_r[i] - 8'(cnt_r[i] != 8'h00);
    // Pulse inverts the idle level, wide enough to pass the input filter
    always_comb
        for (int i = 0; i < 4; i++)
            trig[i] = idle_lvl[i] ^ (cnt_r[i] != 8'h00);
endmodule // dwte_trig_src

// [dwte_top_test.sv]
// Self-checking bench of the trigger engine
`timescale 1ns/100ps
module dwte_top_test;
    typedef struct packed {logic [7:0] a; logic [31:0] e;} dwte_row_t;
    dwte_row_t   rows [9] = '{'{8'h04, 32'h0}, '{8'h08, 32'h10}, '{8'h0C, 32'h0},
        '{8'h10, 32'h2}, '{8'h14, 32'hA}, '{8'h20, 32'h2}, '{8'h24, 32'h10},
        '{8'h3C, 32'h0}, '{8'h00, 32'h0}};
    logic        clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = '0, do_data;
    logic [31:0] wdat = '0, q, dat_o;
    logic [3:0]  fire = '0, trig;
    logic        ack, pio_o, pio_oe, active;
    int          mismatches = 0, n_compared = 0, n_exp = 0, cycles = 0;
    always #25 clk_sys = ~clk_sys;
    dwte_trig_src i_src (.clk(clk_sys), .idle_lvl(4'h0), .fire(fire), .trig(trig));
    dwte_top i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .INPUT_START_TRIGGER(trig[0]), .INPUT_REFERENCE_TRIGGER(trig[1]),
        .INPUT_PAUSE_TRIGGER(trig[2]), .INPUT_SAMPLE_CLOCK(trig[3]), .DI_DATA_I(8'h5A),
        .DO_DATA_O(do_data), .PROGRAMMABLE_IO_LINE_I(1'b0), .PROGRAMMABLE_IO_LINE_O(pio_o),
        .PROGRAMMABLE_IO_LINE_OE(pio_oe), .ACQ_ACTIVE_O(active));
    always @(posedge clk_sys)
    begin
        n_exp += (pio_o === 1'b1);
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle: hold the request until ack is sampled, then one idle cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(q & m, e);
    endtask
    task finish_acq;
        while (active !== 1'b0) @(posedge clk_sys);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) rdc(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
        $display("test reset values done");
        wb(1'b1, 8'h08, 32'h3); wb(1'b1, 8'h14, 32'h2); wb(1'b1, 8'h00, 32'h1);
        finish_acq();
        rdc(8'h18, 32'h1F01, 32'h0300);
        repeat (3) rdc(8'h1C, 32'hFF, 32'h5A);
        $display("test software start done");
        wb(1'b1, 8'h04, 32'h103); wb(1'b1, 8'h08, 32'h2); wb(1'b1, 8'h00, 32'h1);
        fire <= 4'h1;
        @(posedge clk_sys);
        fire <= 4'h0;
        repeat (10) @(posedge clk_sys);
        check(32'(n_exp), 32'h0);
        repeat (12) @(posedge clk_sys);
        check(32'(n_exp), 32'h1);
        finish_acq();
        rdc(8'h18, 32'h1F01, 32'h0200);
        check({31'h0, pio_oe}, 32'h1);
        $display("test falling trigger done");
        wb(1'b1, 8'h20, 32'h0); wb(1'b1, 8'h24, 32'h1); wb(1'b1, 8'h28, 32'hC3);
        wb(1'b1, 8'h00, 32'h4);
        repeat (20) @(posedge clk_sys);
        check({24'h0, do_data}, 32'hC3);
        rdc(8'h18, 32'h1F_0022, 32'h0);
        wb(1'b1, 8'h00, 32'h4);
        repeat (20) @(posedge clk_sys);
        rdc(8'h18, 32'h20, 32'h20);
        check({24'h0, do_data}, 32'hC3);
        wb(1'b1, 8'h00, 32'h10);
        rdc(8'h18, 32'h20, 32'h0);
        $display("test generation done");
        wb(1'b1, 8'h04, 32'h10); wb(1'b1, 8'h08, 32'h4); wb(1'b1, 8'h0C, 32'h3);
        wb(1'b1, 8'h00, 32'h1);
        fire <= 4'h2;
        @(posedge clk_sys);
        fire <= 4'h0;
        repeat (20) @(posedge clk_sys);
        fire <= 4'h2;
        @(posedge clk_sys);
        fire <= 4'h0;
        finish_acq();
        rdc(8'h18, 32'h1F19, 32'h0408);
        $display("test reference trigger done");
        wb(1'b1, 8'h04, 32'h5); wb(1'b1, 8'h08, 32'h2); wb(1'b1, 8'h00, 32'h1);
        repeat (2)
        begin
            fire <= 4'h1;
            @(posedge clk_sys);
            fire <= 4'h0;
            repeat (20) @(posedge clk_sys);
        end
        rdc(8'h18, 32'h1F01, 32'h0801);
        wb(1'b1, 8'h00, 32'h2);
        rdc(8'h18, 32'h1, 32'h0);
        $display("test retrigger done");
        conclude();
    end
endmodule // dwte_top_test
